// ==== verilog/cable_test_pkg.sv ====
// Constants and types shared by the cable reflection test block.
package cable_test_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] result_off = 8'h1c;
  localparam logic [7:0] page_sel_off = 8'h20;
  localparam logic [7:0] int_status_off = 8'h24;
  localparam logic [7:0] int_mask_off = 8'h28;
  localparam int addr_w = 8;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int run_bit = 15;
  localparam int skip_wait_bit = 15;
  localparam int verdict_lo = 13;
  localparam int amp_lo = 8;
  localparam int dist_lo = 0;
  localparam int result_w = 15;
  localparam int page_w = 2;
  localparam logic [1:0] pair0_page = 2'h0;
  localparam logic [1:0] pair1_page = 2'h1;
  localparam logic [1:0] pair2_page = 2'h2;
  localparam int num_pairs = 3;
  localparam int int_w = 2;
  localparam int int_done_bit = 0;
  localparam int int_fault_bit = 1;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [1:0] verdict_normal = 2'h0;
  localparam logic [1:0] verdict_short = 2'h1;
  localparam logic [1:0] verdict_open = 2'h2;
  localparam logic [1:0] verdict_fail = 2'h3;
  localparam logic [4:0] amp_zero = 5'h10;
  localparam logic [4:0] amp_min = 5'h07;
  localparam logic [4:0] amp_max = 5'h1f;
  localparam logic [14:0] result_rst = 15'h0000;
  localparam logic [1:0] page_rst = 2'h0;
  localparam logic [1:0] int_rst = 2'h0;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {
    st_idle,
    st_wait_link,
    st_run
  } test_state_t;

endpackage

// ==== verilog/pair_result_store.sv ====
// Holds the verdict, amplitude and distance of one twisted pair.
`timescale 1ns/10ps
module pair_result_store
  import cable_test_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [1:0] verdict,
  input wire logic [4:0] amplitude,
  input wire logic [7:0] distance,
  output logic [result_w-1:0] result
);

  typedef struct packed {
    logic [1:0] verdict;
    logic [4:0] amplitude;
    logic [7:0] distance;
  } store_t;

  store_t s_ff;
  store_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (load) begin
      nxt_s.verdict = verdict;
      if (amplitude < amp_min) begin
        nxt_s.amplitude = amp_min;
      end else begin
        nxt_s.amplitude = amplitude;
      end
      nxt_s.distance = distance;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= store_t'(result_rst);
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign result = {s_ff.verdict, s_ff.amplitude, s_ff.distance};

endmodule

// ==== verilog/cable_reflect_test.sv ====
// AXI4-Lite register block and sequencer for the cable reflection test.
`timescale 1ns/10ps
module cable_reflect_test
  import cable_test_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset,
  input wire logic [addr_w-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [addr_w-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_up,
  output logic link_down_req,
  output logic run_cable_test,
  input wire logic meas_valid,
  input wire logic [1:0] meas_pair,
  input wire logic [1:0] meas_verdict,
  input wire logic [4:0] meas_amplitude,
  input wire logic [7:0] meas_distance,
  input wire logic meas_done,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [addr_w-1:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic [page_w-1:0] page;
    logic skip_wait;
    logic run;
    test_state_t st;
    logic start;
    logic link_down_req;
    logic [int_w-1:0] int_status;
    logic [int_w-1:0] int_mask;
    logic irq;
  } block_t;

  block_t s_ff;
  block_t nxt_s;
  logic [result_w-1:0] pair_result [num_pairs];
  logic [num_pairs-1:0] pair_load;

  // ****************************************************************
  // Per-pair result stores
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < num_pairs; gi++) begin : g_pair
      assign pair_load[gi] = meas_valid && (s_ff.st == st_run) &&
                             (meas_pair == 2'(gi));
      pair_result_store u_store (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(pair_load[gi]),
        .verdict(meas_verdict),
        .amplitude(meas_amplitude),
        .distance(meas_distance),
        .result(pair_result[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Read decode
  // ****************************************************************
  function automatic logic [15:0] result_word(input logic [page_w-1:0] page,
                                              input logic run,
                                              input logic skip_wait,
                                              input logic [result_w-1:0] r0,
                                              input logic [result_w-1:0] r1,
                                              input logic [result_w-1:0] r2);
    logic [15:0] w;
    w = 16'h0000;
    case (page)
      pair0_page: begin
        w = {run, r0};
      end
      pair1_page: begin
        w = {skip_wait, r1};
      end
      pair2_page: begin
        w = {1'b0, r2};
      end
      default: begin
        w = 16'h0000;
      end
    endcase
    return w;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic wr_go;
    logic [int_w-1:0] evt;
    logic [int_w-1:0] clr;
    wr_go = 1'b0;
    evt = '0;
    clr = '0;
    nxt_s = s_ff;
    nxt_s.start = 1'b0;

    // ****************************************************************
    // Write path
    // ****************************************************************
    // Write address and data are taken in either order.
    if (s_ff.awready && s_axi_awvalid) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
      nxt_s.awready = 1'b0;
    end
    if (s_ff.wready && s_axi_wvalid) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata[15:0];
      nxt_s.wstrb = s_axi_wstrb[1:0];
      nxt_s.wready = 1'b0;
    end
    wr_go = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    if (wr_go) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = resp_okay;
      case (s_ff.awaddr)
        result_off: begin
          if (s_ff.wstrb[1] && s_ff.page == pair0_page) begin
            if (s_ff.wdata[run_bit] && !s_ff.run) begin
              nxt_s.run = 1'b1;
            end
          end else if (s_ff.wstrb[1] && s_ff.page == pair1_page) begin
            nxt_s.skip_wait = s_ff.wdata[skip_wait_bit];
          end
        end
        page_sel_off: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.page = s_ff.wdata[page_w-1:0];
          end
        end
        int_status_off: begin
          if (s_ff.wstrb[0]) begin
            clr = s_ff.wdata[int_w-1:0];
          end
        end
        int_mask_off: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.int_mask = s_ff.wdata[int_w-1:0];
          end
        end
        default: begin
          nxt_s.bresp = resp_slverr;
        end
      endcase
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
      nxt_s.awready = 1'b1;
      nxt_s.wready = 1'b1;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // A read is answered one cycle after its address is taken.
    if (s_ff.arready && s_axi_arvalid) begin
      nxt_s.arready = 1'b0;
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = resp_okay;
      case (s_axi_araddr)
        result_off: begin
          nxt_s.rdata = {16'h0000, result_word(s_ff.page, s_ff.run, s_ff.skip_wait,
                                               pair_result[0], pair_result[1],
                                               pair_result[2])};
        end
        page_sel_off: begin
          nxt_s.rdata = {30'h0000_0000, s_ff.page};
        end
        int_status_off: begin
          nxt_s.rdata = {30'h0000_0000, s_ff.int_status};
        end
        int_mask_off: begin
          nxt_s.rdata = {30'h0000_0000, s_ff.int_mask};
        end
        default: begin
          nxt_s.rdata = 32'h0000_0000;
          nxt_s.rresp = resp_slverr;
        end
      endcase
    end
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
      nxt_s.arready = 1'b1;
    end

    // ****************************************************************
    // Test sequencer
    // ****************************************************************
    // Test sequencer.
    case (s_ff.st)
      st_idle: begin
        nxt_s.link_down_req = 1'b0;
        if (s_ff.run) begin
          if (s_ff.skip_wait) begin
            nxt_s.st = st_run;
            nxt_s.start = 1'b1;
          end else begin
            nxt_s.st = st_wait_link;
            nxt_s.link_down_req = 1'b1;
          end
        end
      end
      st_wait_link: begin
        if (!link_up) begin
          nxt_s.st = st_run;
          nxt_s.start = 1'b1;
        end
      end
      st_run: begin
        if (meas_valid && meas_pair < 2'(num_pairs)) begin
          case (meas_verdict)
            verdict_short: begin
              evt[int_fault_bit] = 1'b1;
            end
            verdict_open: begin
              evt[int_fault_bit] = 1'b1;
            end
            verdict_fail: begin
              evt[int_fault_bit] = 1'b1;
            end
            default: begin
              evt[int_fault_bit] = 1'b0;
            end
          endcase
        end
        if (meas_done) begin
          nxt_s.run = 1'b0;
          nxt_s.link_down_req = 1'b0;
          nxt_s.st = st_idle;
          evt[int_done_bit] = 1'b1;
        end
      end
      default: begin
        nxt_s.st = st_idle;
      end
    endcase

    // Software reset aborts a test but the results survive it.
    if (soft_reset) begin
      nxt_s.run = 1'b0;
      nxt_s.st = st_idle;
      nxt_s.start = 1'b0;
      nxt_s.link_down_req = 1'b0;
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // An event in the clearing cycle wins over the clear.
    nxt_s.int_status = (s_ff.int_status & ~clr) | evt;
    nxt_s.irq = |(nxt_s.int_status & nxt_s.int_mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff.awready <= 1'b1;
      s_ff.wready <= 1'b1;
      s_ff.bvalid <= 1'b0;
      s_ff.bresp <= resp_okay;
      s_ff.arready <= 1'b1;
      s_ff.rvalid <= 1'b0;
      s_ff.rresp <= resp_okay;
      s_ff.rdata <= 32'h0000_0000;
      s_ff.aw_got <= 1'b0;
      s_ff.w_got <= 1'b0;
      s_ff.awaddr <= '0;
      s_ff.wdata <= 16'h0000;
      s_ff.wstrb <= 2'h0;
      s_ff.page <= page_rst;
      s_ff.skip_wait <= 1'b0;
      s_ff.run <= 1'b0;
      s_ff.st <= st_idle;
      s_ff.start <= 1'b0;
      s_ff.link_down_req <= 1'b0;
      s_ff.int_status <= int_rst;
      s_ff.int_mask <= int_rst;
      s_ff.irq <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rresp = s_ff.rresp;
  assign s_axi_rdata = s_ff.rdata;
  assign link_down_req = s_ff.link_down_req;
  assign run_cable_test = s_ff.start;
  assign irq = s_ff.irq;

endmodule

// ==== tb/cable_test_properties.sv ====
// Port-level assertions for the cable reflection test block.
`timescale 1ns/10ps
module cable_test_properties
  import cable_test_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset,
  input wire logic [addr_w-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_up,
  input wire logic link_down_req,
  input wire logic run_cable_test,
  input wire logic meas_done
);
  logic [addr_w-1:0] ra_ff;
  logic mapped;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
  end
  assign mapped = ra_ff inside {result_off, page_sel_off, int_status_off, int_mask_off};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********
  // Properties
  // ********
  property p_pulse; run_cable_test |=> !run_cable_test; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_down_first; run_cable_test && link_down_req |-> !$past(link_up); endproperty
  a_down_first: assert property (p_down_first) else $error("start with link up");
  property p_down_holds; link_down_req && !meas_done && !soft_reset |=> link_down_req; endproperty
  a_down_holds: assert property (p_down_holds) else $error("link request dropped");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("second read taken");
  property p_amp;
    s_axi_rvalid && ra_ff == result_off && s_axi_rdata[14:0] != 15'h0000
      |-> s_axi_rdata[12:8] >= amp_min;
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude below floor");
  property p_unmapped;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
      && (mapped || (s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0000_0000));
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad read answer");
  c_skip: cover property (run_cable_test && !link_down_req);
  c_wait: cover property (run_cable_test && link_down_req);
  c_unmapped: cover property (s_axi_rvalid && !mapped);
endmodule

// ==== tb/cable_engine_model.sv ====
// Cable and measurement engine model at the far side of the test block.
`timescale 1ns/10ps
module cable_engine_model
  import cable_test_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_down_req,
  input wire logic run_cable_test,
  input wire logic fail_all,
  output logic link_up,
  output logic meas_valid,
  output logic [1:0] meas_pair,
  output logic [1:0] meas_verdict,
  output logic [4:0] meas_amplitude,
  output logic [7:0] meas_distance,
  output logic meas_done,
  output logic link_was_up
);
  logic [3:0] step_ff;
  logic [7:0] pat_ff = 8'h00;
  logic [1:0] p;
  assign p = 2'(step_ff - 4'h4);
  assign meas_valid = step_ff inside {[4'h4:4'h6]};
  assign meas_done = step_ff == 4'h9;
  // Idle data lines churn, so a stale value never passes for a result.
  assign meas_pair = meas_valid ? p : pat_ff[1:0];
  assign meas_verdict = !meas_valid ? pat_ff[3:2] : fail_all ? verdict_fail : p;
  assign meas_amplitude = !meas_valid ? pat_ff[4:0] : p == 2'h0 ? amp_zero : p[0] ? amp_max : 5'h03;
  assign meas_distance = meas_valid ? 8'h40 + 8'(p) : pat_ff;
  always_ff @(posedge aclk) begin
    pat_ff <= pat_ff + 8'h5b;
    link_up <= !link_down_req;
    if (run_cable_test) link_was_up <= link_up;
    if (!aresetn) step_ff <= 4'h0;
    else if (run_cable_test) step_ff <= 4'h1;
    else if (step_ff != 4'h0) step_ff <= step_ff == 4'h9 ? 4'h0 : step_ff + 4'h1;
  end
endmodule

// ==== tb/cable_reflect_test_tb.sv ====
// Self-checking bench for the cable reflection test block.
`timescale 1ns/10ps
module cable_reflect_test_tb;
  import cable_test_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, soft_reset = 1'h0, fail_all = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, keep;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic link_up, link_down_req, run_cable_test, meas_valid, meas_done, link_was_up;
  logic [1:0] s_axi_bresp, s_axi_rresp, meas_pair, meas_verdict;
  logic [4:0] meas_amplitude;
  logic [7:0] meas_distance;
  int bad_count = 0;
  int checks = 0;
  cable_reflect_test cable_reflect_test_i (
    .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .link_up(link_up), .link_down_req(link_down_req), .run_cable_test(run_cable_test),
    .meas_valid(meas_valid), .meas_pair(meas_pair), .meas_verdict(meas_verdict),
    .meas_amplitude(meas_amplitude), .meas_distance(meas_distance),
    .meas_done(meas_done), .irq(irq)
  );
  cable_engine_model cable_engine_model_i (
    .aclk(aclk), .aresetn(aresetn), .link_down_req(link_down_req),
    .run_cable_test(run_cable_test), .fail_all(fail_all), .link_up(link_up),
    .meas_valid(meas_valid), .meas_pair(meas_pair), .meas_verdict(meas_verdict),
    .meas_amplitude(meas_amplitude), .meas_distance(meas_distance),
    .meas_done(meas_done), .link_was_up(link_was_up)
  );
  always #25 aclk = ~aclk;
  // ********
  // Bus tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask
  task automatic rd_page(input logic [1:0] p);
    wr(page_sel_off, {30'h0, p});
    rd_reg(result_off);
  endtask
  function automatic logic [14:0] expect_pair(input int p, input logic f);
    logic [4:0] amp;
    amp = p == 0 ? amp_zero : p == 1 ? amp_max : amp_min;
    expect_pair = {f ? verdict_fail : 2'(p), amp, 8'(8'h40 + p)};
  endfunction
  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    for (int p = 0; p < 4; p++) begin
      rd_page(2'(p));
      chk(rd, 32'h0000_0000);
    end
  endtask
  task automatic t_results(input logic skip, input logic f);
    int n;
    logic [31:0] want;
    fail_all <= f;
    wr(page_sel_off, 32'h0000_0001);
    wr(result_off, {16'h0000, skip, 15'h0000});
    wr(page_sel_off, 32'h0000_0000);
    wr(result_off, 32'h0000_8000);
    n = 0;
    // Results are trusted only once the run bit reads back clear.
    do begin
      rd_reg(result_off);
      n++;
    end while (rd[run_bit] && n < 100);
    chk(rd[run_bit], 1'h0);
    chk(link_was_up, skip);
    for (int p = 0; p < num_pairs; p++) begin
      rd_page(2'(p));
      want = {16'h0000, p == 1 && skip, expect_pair(p, f)};
      chk(rd[14:13], want[14:13]);
      chk(rd[12:8], want[12:8]);
      chk(rd, want);
    end
  endtask
  task automatic t_irq;
    rd_reg(int_status_off);
    chk(rd[int_done_bit], 1'h1);
    chk(rd[int_fault_bit], 1'h1);
    chk(irq, 1'h0);
    wr(int_mask_off, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h1);
    wr(int_status_off, 32'h0000_0003);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h0);
    rd_reg(int_status_off);
    chk(rd, 32'h0000_0000);
    wr(int_mask_off, 32'h0000_0000);
  endtask
  task automatic t_soft;
    rd_page(2'h2);
    keep = rd;
    wr(result_off, {keep[31:15], ~keep[14:0]});
    // A test started just before the software reset must be cut short.
    wr(page_sel_off, 32'h0000_0000);
    wr(result_off, 32'h0000_8000);
    @(posedge aclk);
    soft_reset <= 1'h1;
    repeat (2) @(posedge aclk);
    soft_reset <= 1'h0;
    rd_reg(result_off);
    chk(rd, {16'h0000, 1'h0, expect_pair(0, 1'h1)});
    rd_page(2'h2);
    chk(rd, keep);
    wr(8'h40, 32'hffff_ffff, resp_slverr);
    rd_reg(8'h40, resp_slverr);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_results(1'h1, 1'h0);
    t_irq;
    t_results(1'h0, 1'h1);
    t_soft;
    tally_and_finish;
  end
  // A hang is cut short well past the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    tally_and_finish;
  end
endmodule
bind cable_reflect_test cable_test_properties cable_test_properties_i (
  .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .link_up(link_up), .link_down_req(link_down_req),
  .run_cable_test(run_cable_test), .meas_done(meas_done)
);
